// ### rtl/jtag_bscan_pkg.sv
// Constants and types shared by the boundary-scan instruction decoder.
package jtag_bscan_pkg;

   // ------------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------------
   localparam int BSC_LEN = 8;
   localparam int IR_LEN = 4;
   localparam int SYNC_W = 3 + BSC_LEN;

   // ------------------------------------------------------------------
   // Instruction codes
   // ------------------------------------------------------------------
   localparam logic [IR_LEN-1:0] IR_EXTEST = 4'h0;
   localparam logic [IR_LEN-1:0] IR_SAMPLE = 4'h1;
   localparam logic [IR_LEN-1:0] IR_INTEST = 4'h4;
   localparam logic [IR_LEN-1:0] IR_CLAMP = 4'h5;
   localparam logic [IR_LEN-1:0] IR_ABORT = 4'h8;
   localparam logic [IR_LEN-1:0] IR_DPACC = 4'hA;
   localparam logic [IR_LEN-1:0] IR_APACC = 4'hB;
   localparam logic [IR_LEN-1:0] IR_RSVD_C = 4'hC;
   localparam logic [IR_LEN-1:0] IR_RSVD_D = 4'hD;
   localparam logic [IR_LEN-1:0] IR_IDCODE = 4'hE;
   localparam logic [IR_LEN-1:0] IR_BYPASS = 4'hF;

   // ------------------------------------------------------------------
   // Reset values and capture layout
   // ------------------------------------------------------------------
   localparam logic [IR_LEN-1:0] IR_RESET = IR_IDCODE;
   localparam logic PROT_RESET = 1'b1;
   localparam logic TDO_RESET = 1'b0;
   localparam int CAP_PROT_POS = 0;
   localparam int CAP_DONE_POS = 3;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [3:0] {
      TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
      SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
   } tap_state_t;

   typedef struct packed {
      logic abort;
      logic dpacc;
      logic apacc;
      logic idcode;
   } dp_instr_t;

   typedef struct packed {
      logic [BSC_LEN-1:0] pin;
      logic tdi;
      logic tms;
      logic tck;
   } jtag_raw_t;

endpackage : jtag_bscan_pkg

// ### rtl/jtag_boundary_scan_tap.sv
// Boundary-scan TAP with instruction decode, TDO routing and protection gate.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Code 0000 selects the boundary chain for testing outside circuitry.
// - Code 0001 selects the boundary chain for a pin snapshot, system undisturbed.
// - Code 0100 selects the boundary chain for testing internal logic.
// - Code 0101 uses the bypass bit while pins stay driven from update latches.
// - Codes 1000, 1010, 1011, 1110 decode as debug port instructions.
// - Code 1111 puts the one-bit bypass register between TDI and TDO.
// - Protected state blocks system bus access port requests; JTAG stays usable.
// - Only a chip erase releases protection and restores bus port access.
// - A newly programmed security bit shows only after a system reset.
// - All patterns shift least significant bit first.
// - Capture-IR loads protect bit, two zeros and startup-done bit.
// - Capture-IR latches the status value into the instruction shifter.
// - Shift-IR advances the instruction shifter one bit per TCK.
// - Update-IR to EXTEST drives the update latches onto the pins at once.
// - EXTEST Capture-DR samples the external pin levels.
// - Boundary chain shifts one place per TCK in Shift-DR.
// - EXTEST Update-DR moves the chain into the pin drivers.
// - SAMPLE_PRELOAD never changes the update latches.
// - SAMPLE_PRELOAD Capture-DR samples the external pin levels.
// - TDO comes from this TAP in Shift-IR and for its codes, else from the debug port.
// - In serial-wire mode the boundary TAP and its codes are unavailable.
// - Test-Logic-Reset holds the port logic in synchronous reset.
module jtag_boundary_scan_tap
   import jtag_bscan_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdo_oe_n,
   input wire logic swd_mode,
   input wire logic dp_tdo,
   output dp_instr_t dp_instr,
   output logic bscan_tdo_sel,
   input wire logic [BSC_LEN-1:0] pin_in,
   input wire logic [BSC_LEN-1:0] core_out,
   output logic [BSC_LEN-1:0] pin_out,
   output logic bs_drive,
   output logic [BSC_LEN-1:0] core_in,
   input wire logic security_bit,
   input wire logic startup_done,
   input wire logic chip_erase_done,
   input wire logic ap_req,
   output logic ap_grant,
   output logic protected_state
);

   // ------------------------------------------------------------------
   // Input synchronisers and glitch filter
   // ------------------------------------------------------------------
   logic [SYNC_W-1:0] raw;
   logic [SYNC_W-1:0] s1_q;
   logic [SYNC_W-1:0] s2_q;
   logic [SYNC_W-1:0] s3_q;
   logic [SYNC_W-1:0] filt_q;
   jtag_raw_t fv;

   assign raw = {pin_in, tdi, tms, tck};
   assign fv = jtag_raw_t'(filt_q);

   for (genvar i = 0; i < SYNC_W; i++) begin : g_sync
      always_ff @(posedge core_clk or negedge rst_n) begin
         if (!rst_n) begin
            s1_q[i] <= 1'b0;
            s2_q[i] <= 1'b0;
            s3_q[i] <= 1'b0;
            filt_q[i] <= 1'b0;
         end else begin
            s1_q[i] <= raw[i];
            s2_q[i] <= s1_q[i];
            s3_q[i] <= s2_q[i];
            // Accept a change only once two stages agree
            if (s2_q[i] == s3_q[i]) begin
               filt_q[i] <= s3_q[i];
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // TCK edge detection
   // ------------------------------------------------------------------
   logic tck_prev_q;
   wire tck_rise = fv.tck & ~tck_prev_q;
   wire tck_fall = ~fv.tck & tck_prev_q;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tck_prev_q <= 1'b0;
      end else begin
         tck_prev_q <= fv.tck;
      end
   end

   // ------------------------------------------------------------------
   // TAP state machine
   // ------------------------------------------------------------------
   tap_state_t state_q;
   tap_state_t state_d;
   wire m = fv.tms;

   always_comb begin
      case (state_q)
         TLR: state_d = m ? TLR : RTI;
         RTI: state_d = m ? SEL_DR : RTI;
         SEL_DR: state_d = m ? SEL_IR : CAP_DR;
         CAP_DR: state_d = m ? EX1_DR : SH_DR;
         SH_DR: state_d = m ? EX1_DR : SH_DR;
         EX1_DR: state_d = m ? UPD_DR : PA_DR;
         PA_DR: state_d = m ? EX2_DR : PA_DR;
         EX2_DR: state_d = m ? UPD_DR : SH_DR;
         UPD_DR: state_d = m ? SEL_DR : RTI;
         SEL_IR: state_d = m ? TLR : CAP_IR;
         CAP_IR: state_d = m ? EX1_IR : SH_IR;
         SH_IR: state_d = m ? EX1_IR : SH_IR;
         EX1_IR: state_d = m ? UPD_IR : PA_IR;
         PA_IR: state_d = m ? EX2_IR : PA_IR;
         EX2_IR: state_d = m ? UPD_IR : SH_IR;
         UPD_IR: state_d = m ? SEL_DR : RTI;
         default: state_d = TLR;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= TLR;
      end else if (tck_rise) begin
         state_q <= state_d;
      end
   end

   // ------------------------------------------------------------------
   // Protection state
   // ------------------------------------------------------------------
   logic prot_q;
   logic prot_loaded_q;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         prot_q <= PROT_RESET;
         prot_loaded_q <= 1'b0;
      end else if (!prot_loaded_q) begin
         // Security bit is looked at once per system reset
         prot_q <= security_bit;
         prot_loaded_q <= 1'b1;
      end else if (chip_erase_done) begin
         prot_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Instruction decode
   // ------------------------------------------------------------------
   logic [IR_LEN-1:0] ir_q;
   logic [IR_LEN-1:0] ir_sr_q;
   logic [IR_LEN-1:0] ir_cap;
   wire bs_ok = ~swd_mode;
   wire is_ext = bs_ok & (ir_q == IR_EXTEST);
   wire is_samp = bs_ok & (ir_q == IR_SAMPLE);
   wire is_int = bs_ok & (ir_q == IR_INTEST);
   wire is_clamp = bs_ok & (ir_q == IR_CLAMP);
   wire is_abort = ir_q == IR_ABORT;
   wire is_dpacc = ir_q == IR_DPACC;
   wire is_apacc = ir_q == IR_APACC;
   wire is_idcode = ir_q == IR_IDCODE;
   wire is_dp = is_abort | is_dpacc | is_apacc | is_idcode;
   wire bs_recog = bs_ok & ~is_dp;
   wire chain_sel = is_ext | is_samp | is_int;
   // Bypass, reserved and unused codes all take the bypass bit
   wire bypass_sel = bs_recog & ~chain_sel;
   wire drive_d = is_ext | is_int | is_clamp;
   dp_instr_t dp_d;

   assign dp_d.abort = bs_ok & is_abort;
   assign dp_d.dpacc = bs_ok & is_dpacc;
   assign dp_d.apacc = bs_ok & is_apacc;
   assign dp_d.idcode = bs_ok & is_idcode;

   always_comb begin
      ir_cap = '0;
      ir_cap[CAP_PROT_POS] = prot_q;
      ir_cap[CAP_DONE_POS] = startup_done;
   end

   // ------------------------------------------------------------------
   // Instruction register
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ir_q <= IR_RESET;
         ir_sr_q <= '0;
      end else if (tck_rise) begin
         case (state_q)
            TLR: ir_q <= IR_RESET;
            CAP_IR: ir_sr_q <= ir_cap;
            SH_IR: ir_sr_q <= {fv.tdi, ir_sr_q[IR_LEN-1:1]};
            UPD_IR: ir_q <= ir_sr_q;
            default: ir_q <= ir_q;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Boundary chain, update latches and bypass bit
   // ------------------------------------------------------------------
   logic [BSC_LEN-1:0] bsc_q;
   logic [BSC_LEN-1:0] upd_q;
   logic byp_q;
   logic [BSC_LEN-1:0] cap_src;

   // Internal test captures the core's outputs, the others the pins
   assign cap_src = is_int ? core_out : fv.pin;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bsc_q <= '0;
      end else if (tck_rise) begin
         if (state_q == TLR) begin
            bsc_q <= '0;
         end else if (state_q == CAP_DR && chain_sel) begin
            bsc_q <= cap_src;
         end else if (state_q == SH_DR && chain_sel) begin
            bsc_q <= {fv.tdi, bsc_q[BSC_LEN-1:1]};
         end
      end
   end

   // Preload under sample leaves the latches alone
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         upd_q <= '0;
      end else if (tck_rise) begin
         if (state_q == TLR) begin
            upd_q <= '0;
         end else if (state_q == UPD_DR && (is_ext | is_int)) begin
            upd_q <= bsc_q;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         byp_q <= 1'b0;
      end else if (tck_rise) begin
         if (state_q == TLR) begin
            byp_q <= 1'b0;
         end else if (state_q == CAP_DR && bypass_sel) begin
            byp_q <= 1'b0;
         end else if (state_q == SH_DR && bypass_sel) begin
            byp_q <= fv.tdi;
         end
      end
   end

   // ------------------------------------------------------------------
   // TDO, changed on the falling TCK edge
   // ------------------------------------------------------------------
   wire sh_ir = state_q == SH_IR;
   wire sh_dr = state_q == SH_DR;
   wire dr_bit = chain_sel ? bsc_q[0] : byp_q;
   wire own_bit = sh_ir ? ir_sr_q[0] : dr_bit;
   wire tdo_d = (bs_recog | sh_ir) ? own_bit : dp_tdo;
   wire oe_n_d = ~((sh_ir | sh_dr) & bs_ok);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tdo <= TDO_RESET;
         tdo_oe_n <= 1'b1;
      end else if (tck_fall) begin
         tdo <= tdo_d;
         tdo_oe_n <= oe_n_d;
      end
   end

   // ------------------------------------------------------------------
   // Registered outputs
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         dp_instr <= '0;
      end else begin
         dp_instr <= dp_d;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bscan_tdo_sel <= 1'b0;
      end else begin
         bscan_tdo_sel <= bs_recog;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_out <= '0;
      end else begin
         pin_out <= drive_d ? upd_q : core_out;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bs_drive <= 1'b0;
      end else begin
         bs_drive <= drive_d;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         core_in <= '0;
      end else begin
         core_in <= is_int ? upd_q : fv.pin;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ap_grant <= 1'b0;
      end else begin
         ap_grant <= ap_req & ~prot_q;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         protected_state <= PROT_RESET;
      end else begin
         protected_state <= prot_q;
      end
   end

endmodule : jtag_boundary_scan_tap
`default_nettype wire

// ### dv/jtag_boundary_scan_tap_asserts.sv
// Port-level checks for the boundary-scan decoder.
`timescale 1ns/1ps
`default_nettype none
module jtag_boundary_scan_tap_asserts
   import jtag_bscan_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic tck,
   input wire logic swd_mode,
   input wire logic [BSC_LEN-1:0] core_out,
   input wire logic [BSC_LEN-1:0] pin_out,
   input wire logic bs_drive,
   input wire logic tdo,
   input wire logic tdo_oe_n,
   input wire dp_instr_t dp_instr,
   input wire logic bscan_tdo_sel,
   input wire logic chip_erase_done,
   input wire logic ap_req,
   input wire logic ap_grant,
   input wire logic protected_state
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   a_grant_locked: assert property (ap_grant |-> !protected_state)
      else $error("bus port granted while protected");
   a_grant_open: assert property ($past(ap_req) && !protected_state |-> ap_grant)
      else $error("bus port refused while open");
   a_swd_off: assert property (swd_mode |=> !bscan_tdo_sel && dp_instr == 4'h0 && tdo_oe_n)
      else $error("boundary tap active in serial-wire mode");
   a_dp_onehot: assert property ($onehot0(dp_instr))
      else $error("debug decode not one-hot");
   a_dp_route: assert property (|dp_instr |-> !bscan_tdo_sel)
      else $error("debug code routed to boundary tap");
   a_core_pass: assert property (!bs_drive && $past(!bs_drive) && $past(rst_n)
      |-> pin_out == $past(core_out))
      else $error("pins disturbed without drive");
   a_tdo_fall: assert property ($changed(tdo) || $changed(tdo_oe_n) |-> !$past(tck, 2))
      else $error("tdo moved away from a tck fall");
   a_erase_clear: assert property (chip_erase_done |-> ##2 !protected_state)
      else $error("erase left protection set");
   a_no_relock: assert property (!protected_state |=> !protected_state)
      else $error("protection set without reset");
   cover property ($rose(bs_drive));
   cover property ($fell(protected_state));
   cover property (!tdo_oe_n && bscan_tdo_sel);
endmodule : jtag_boundary_scan_tap_asserts
`default_nettype wire

// ### dv/jtag_host_model.sv
// Behavioural JTAG tester driving scans into the decoder.
`timescale 1ns/1ps
`default_nettype none
module jtag_host_model (
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo,
   input wire logic tdo_oe_n
);
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // One tck period; tdo is read just before the fall
   task automatic step(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      #400 tck = 1'b1;
      // Released line reads inverted, so a missing enable shows up
      #400 q = tdo_oe_n ? ~tdo : tdo;
      tck = 1'b0;
   endtask : step
   task automatic tlr();
      logic q;
      repeat (5) step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
   endtask : tlr
   // Scan n bits from idle and return to idle; tck stands low after
   task automatic scan(input logic ir, input int n, input logic [7:0] din,
      output logic [7:0] dout);
      logic q;
      #37;
      dout = 8'h00;
      step(1'b1, 1'b0, q);
      if (ir) step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
      step(1'b0, 1'b0, q);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], q);
         dout[i] = q;
      end
      step(1'b1, ~din[n-1], q);
      step(1'b0, din[n-1], q);
   endtask : scan
endmodule : jtag_host_model
`default_nettype wire

// ### dv/jtag_boundary_scan_tap_bench.sv
// Self-checking bench for the boundary-scan decoder.
`timescale 1ns/1ps
`default_nettype none
module jtag_boundary_scan_tap_bench
   import jtag_bscan_pkg::*;
;
   logic core_clk, rst_n, tck, tms, tdi, tdo, tdo_oe_n, swd_mode, dp_tdo, sel, bs_drive;
   logic security_bit, startup_done, chip_erase_done, ap_req, ap_grant, prot;
   logic [BSC_LEN-1:0] pin_in, core_out, pin_out, core_in, rd;
   dp_instr_t dp_instr;
   int errors, num_checks;
   jtag_boundary_scan_tap i_dut (.core_clk(core_clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
      .tdo(tdo), .tdo_oe_n(tdo_oe_n), .swd_mode(swd_mode), .dp_tdo(dp_tdo), .dp_instr(dp_instr),
      .bscan_tdo_sel(sel), .pin_in(pin_in), .core_out(core_out), .pin_out(pin_out),
      .bs_drive(bs_drive), .core_in(core_in), .security_bit(security_bit), .ap_req(ap_req),
      .startup_done(startup_done), .chip_erase_done(chip_erase_done), .ap_grant(ap_grant),
      .protected_state(prot));
   jtag_host_model i_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n));
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_b(input logic got, input logic exp);
      chk({7'h00, got}, {7'h00, exp});
   endtask : chk_b
   task automatic end_sim();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim
   task automatic settle();
      repeat (12) @(negedge core_clk);
   endtask : settle
   task automatic load_ir(input logic [3:0] c);
      i_host.scan(1'b1, 4, {4'h0, c}, rd);
      settle();
   endtask : load_ir
   task automatic t_capture(input logic p);
      load_ir(IR_BYPASS);
      chk(rd, {4'h0, startup_done, 2'b00, p});
      chk_b(prot, p);
   endtask : t_capture
   task automatic t_codes();
      logic [3:0] c, de;
      logic dp;
      for (int i = 0; i < 16; i++) begin
         c = 4'(i);
         dp = c inside {IR_ABORT, IR_DPACC, IR_APACC, IR_IDCODE};
         de = {c == IR_ABORT, c == IR_DPACC, c == IR_APACC, c == IR_IDCODE};
         load_ir(c);
         chk({4'h0, dp_instr}, {4'h0, de});
         chk_b(sel, !dp);
         chk_b(bs_drive, c inside {IR_EXTEST, IR_INTEST, IR_CLAMP});
         if (!(c inside {IR_EXTEST, IR_SAMPLE, IR_INTEST})) begin
            i_host.scan(1'b0, 4, 8'h0B, rd);
            chk(rd, dp ? 8'h0F : 8'h06);
         end
      end
   endtask : t_codes
   task automatic t_boundary();
      pin_in = 8'hA5;
      core_out = 8'hC3;
      load_ir(IR_SAMPLE);
      i_host.scan(1'b0, 8, 8'h3C, rd);
      chk(rd, 8'hA5);
      load_ir(IR_EXTEST);
      chk(pin_out, 8'h00);
      i_host.scan(1'b0, 8, 8'h5A, rd);
      settle();
      chk(rd, 8'hA5);
      chk(pin_out, 8'h5A);
      i_host.scan(1'b0, 4, 8'h03, rd);
      settle();
      chk(pin_out, 8'h3A);
      load_ir(IR_INTEST);
      chk(core_in, 8'h3A);
      load_ir(IR_BYPASS);
      chk(core_in, 8'hA5);
      chk(pin_out, 8'hC3);
   endtask : t_boundary
   task automatic t_swd();
      swd_mode = 1'b1;
      load_ir(IR_EXTEST);
      chk({5'h00, bs_drive, sel, tdo_oe_n}, 8'h01);
      swd_mode = 1'b0;
      i_host.tlr();
      settle();
   endtask : t_swd
   task automatic t_protect();
      ap_req = 1'b1;
      settle();
      chk_b(ap_grant, 1'b0);
      chip_erase_done = 1'b1;
      @(negedge core_clk);
      chip_erase_done = 1'b0;
      repeat (3) @(negedge core_clk);
      chk_b(ap_grant, 1'b1);
      startup_done = 1'b0;
      t_capture(1'b0);
      rst_n = 1'b0;
      repeat (6) @(negedge core_clk);
      rst_n = 1'b1;
      settle();
      chk_b(prot, 1'b1);
      chk_b(ap_grant, 1'b0);
   endtask : t_protect
   initial begin
      {rst_n, swd_mode, pin_in, core_out, chip_erase_done, ap_req} = '0;
      {dp_tdo, security_bit, startup_done} = 3'h7;
      errors = 0;
      num_checks = 0;
      repeat (6) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (4) @(negedge core_clk);
      i_host.tlr();
      t_capture(1'b1);
      t_codes();
      t_boundary();
      t_swd();
      t_protect();
      end_sim();
   end
   initial begin
      #3ms;
      errors++;
      $display("unexpected at %0t: run did not finish", $time);
      end_sim();
   end
endmodule : jtag_boundary_scan_tap_bench
bind jtag_boundary_scan_tap jtag_boundary_scan_tap_asserts i_chk (.core_clk(core_clk), .rst_n(rst_n),
   .tck(tck), .swd_mode(swd_mode), .core_out(core_out), .pin_out(pin_out), .tdo(tdo),
   .bs_drive(bs_drive), .tdo_oe_n(tdo_oe_n), .dp_instr(dp_instr), .ap_req(ap_req),
   .bscan_tdo_sel(bscan_tdo_sel), .chip_erase_done(chip_erase_done), .ap_grant(ap_grant),
   .protected_state(protected_state));
`default_nettype wire
